// File: aic_bias.sv
// Purpose: Decodes the burnout current select and the diode bias override.
// Assumes: Settings arrive from stored registers; outputs are registered downstream.
// Notes: Has no clock, so conversion state can never gate the current.
`timescale 1ns/1ps
`default_nettype none

module aic_bias
  import aic_pkg::*;
(
  aic_bias_if.dec bus // Settings in, enables out.
);

  logic temp_sel;

  always_comb begin
    temp_sel = (bus.pair_sel[7:4] == AIC_SEL_TEMP_P) || (bus.pair_sel[7:4] == AIC_SEL_TEMP_M) ||
               (bus.pair_sel[3:0] == AIC_SEL_TEMP_P) || (bus.pair_sel[3:0] == AIC_SEL_TEMP_M) ||
               bus.scan_temp;
    // The stored select is only masked here, never rewritten.
    if (temp_sel) begin // see RULE_06
      bus.src_amp = AIC_AMP_NONE;
      bus.snk_amp = AIC_AMP_NONE;
      bus.diode_bias = 1'b1;
    end else begin
      bus.src_amp = aic_amp_decode(bus.cs_sel); // see RULE_01 see RULE_02
      bus.snk_amp = aic_amp_decode(bus.cs_sel); // see RULE_02
      bus.diode_bias = 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: aic_bias_if.sv
// Purpose: Carries bias settings to the bias decoder and its decoded enables back.
// Assumes: Single clock domain, purely combinational decode on the far side.
// Notes: The controller owns the settings, the decoder owns the enables.
`timescale 1ns/1ps
`default_nettype none

interface aic_bias_if;
  logic [1:0] cs_sel;
  logic [7:0] pair_sel;
  logic scan_temp;
  logic [2:0] src_amp;
  logic [2:0] snk_amp;
  logic diode_bias;

  modport ctl (output cs_sel, output pair_sel, output scan_temp,
               input src_amp, input snk_amp, input diode_bias);
  modport dec (input cs_sel, input pair_sel, input scan_temp,
               output src_amp, output snk_amp, output diode_bias);
endinterface

`default_nettype wire

// File: aic_ctl.sv
// Purpose: Register port, burnout bias control and offset cancel conversion sequencing.
// Assumes: The decimation filter signals each finished conversion with i_conv_done.
// Notes: Conversion time is set by the filter; cancellation simply runs it twice.
//
// How it works
// RULE_01: Select 00 gives no current, 01 low, 10 middle, 11 high amplitude.
// RULE_02: Nonzero current is sourced on the positive input and sunk on negative.
// RULE_03: Current enable ignores conversion state, including reset and shutdown.
// RULE_04: Current select accepts writes anytime and takes effect at once.
// RULE_05: Pair code 0xDE routes diode P positive and diode M negative.
// RULE_06: Diode selection masks the burnout current, adds diode bias, keeps stored bits.
// RULE_07: Cancel enable resets to 0; then conversions run normally unswapped.
// RULE_08: With cancel on, each result uses a normal then a swapped conversion.
// RULE_09: With cancel on, output is normal minus swapped, divided by two.
// RULE_10: With cancel on, time per result doubles, single shot included.
// RULE_11: Cancel on in continuous mode resets filter per result, no gap between.
// RULE_12: Upper nibble picks positive source, lower nibble negative; 1101/1110 diodes.
// RULE_13: With cancel on, ready rises only after both halves are combined.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module aic_ctl
  import aic_pkg::*;
(
  input wire logic i_clk, // System clock, 10 MHz.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic [AIC_AW-1:0] i_addr, // Register word offset.
  input wire logic [AIC_DW-1:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [AIC_DW-1:0] o_rdata, // Read data, one cycle after i_rd.
  input wire logic i_scan_temp, // Scan step has selected the diodes.
  input wire logic i_conv_done, // Pulse: filter finished a conversion.
  input wire logic [AIC_RES_W-1:0] i_conv_data, // Filter code with i_conv_done.
  output logic o_conv_start, // Pulse: start one conversion.
  output logic o_filter_rst, // Pulse: clear the decimation filter.
  output logic o_cont_run, // Level: filter runs free.
  output logic o_swap, // Level: inputs swapped.
  output logic [3:0] o_pos_sel, // Source on the positive input.
  output logic [3:0] o_neg_sel, // Source on the negative input.
  output logic [2:0] o_src_amp, // One-hot source current on positive input.
  output logic [2:0] o_snk_amp, // One-hot sink current on negative input.
  output logic o_diode_bias, // Diode bias current on.
  output logic o_busy, // Sequence in progress.
  output logic o_ready // Unread result present.
);

  // ==========================================================================
  // Declarations
  logic [1:0] cs_sel_ff;
  logic [1:0] nxt_cs_sel;
  logic [7:0] pair_ff;
  logic [7:0] nxt_pair;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic az_ff;
  logic nxt_az;
  logic [AIC_DW-1:0] rdata_ff;
  logic [AIC_DW-1:0] nxt_rdata;

  aic_seq_e state_ff;
  aic_seq_e nxt_state;
  logic start_ff;
  logic nxt_start;
  logic frst_ff;
  logic nxt_frst;
  logic cont_ff;
  logic nxt_cont;
  logic swap_ff;
  logic nxt_swap;
  logic load_ff;
  logic nxt_load;
  logic [AIC_RES_W-1:0] norm_ff;
  logic [AIC_RES_W-1:0] nxt_norm;
  logic [AIC_RES_W-1:0] swap_val_ff;
  logic [AIC_RES_W-1:0] nxt_swap_val;
  logic [AIC_RES_W-1:0] result_ff;
  logic [AIC_RES_W-1:0] nxt_result;
  logic ready_ff;
  logic nxt_ready;

  logic [3:0] pos_ff;
  logic [3:0] nxt_pos;
  logic [3:0] neg_ff;
  logic [3:0] nxt_neg;
  logic [2:0] src_ff;
  logic [2:0] snk_ff;
  logic diode_ff;

  logic wr_cmd;
  logic start_req;
  logic stop_req;
  logic join_valid;
  logic [AIC_RES_W-1:0] join_code;
  logic seq_done;
  logic [AIC_RES_W-1:0] seq_code;

  aic_bias_if bias_bus ();

  // ==========================================================================
  // Configuration registers
  // Every register accepts writes in any state; no write is held back for idle.
  always_comb begin
    nxt_cs_sel = cs_sel_ff;
    nxt_pair = pair_ff;
    nxt_mode = mode_ff;
    nxt_az = az_ff;
    if (i_wr) begin
      case (i_addr)
        AIC_OFF_BIAS: begin
          nxt_cs_sel = i_wdata[AIC_CS_LSB +: 2]; // see RULE_04
        end
        AIC_OFF_PAIR: begin
          nxt_pair = i_wdata[7:0];
        end
        AIC_OFF_CONV: begin
          nxt_mode = i_wdata[AIC_MODE_LSB +: 2];
          nxt_az = i_wdata[AIC_AZ_BIT];
        end
        default: begin
          nxt_cs_sel = cs_sel_ff;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cs_sel_ff <= AIC_CS_RST;
      pair_ff <= AIC_PAIR_RST;
      mode_ff <= AIC_MODE_RST;
      az_ff <= AIC_AZ_RST; // see RULE_07
    end else begin
      cs_sel_ff <= nxt_cs_sel;
      pair_ff <= nxt_pair;
      mode_ff <= nxt_mode;
      az_ff <= nxt_az;
    end
  end

  // ==========================================================================
  // Bias decode
  // The decoder sees only stored settings and the scan flag, so reset of the
  // converter sequence or shutdown mode leaves the current untouched.
  assign bias_bus.cs_sel = cs_sel_ff; // see RULE_03
  assign bias_bus.pair_sel = pair_ff;
  assign bias_bus.scan_temp = i_scan_temp;

  aic_bias u_bias (
    .bus (bias_bus)
  );

  // ==========================================================================
  // Input routing
  // Unswapped, positive source is the upper nibble and negative the lower one, so the
  // diode pair code puts diode P positive and diode M negative.
  always_comb begin
    if (nxt_swap) begin
      nxt_pos = pair_ff[3:0];
      nxt_neg = pair_ff[7:4];
    end else begin
      nxt_pos = pair_ff[7:4]; // see RULE_12 see RULE_05
      nxt_neg = pair_ff[3:0]; // see RULE_12 see RULE_05
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pos_ff <= AIC_PAIR_RST[7:4];
      neg_ff <= AIC_PAIR_RST[3:0];
      src_ff <= AIC_AMP_NONE;
      snk_ff <= AIC_AMP_NONE;
      diode_ff <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
      neg_ff <= nxt_neg;
      src_ff <= bias_bus.src_amp; // see RULE_02
      snk_ff <= bias_bus.snk_amp; // see RULE_02
      diode_ff <= bias_bus.diode_bias; // see RULE_06
    end
  end

  // ==========================================================================
  // Conversion sequencer
  assign wr_cmd = i_wr && (i_addr == AIC_OFF_CMD);
  assign start_req = wr_cmd && i_wdata[AIC_CMD_START_BIT] &&
                     ((mode_ff == AIC_MODE_ONESHOT) || (mode_ff == AIC_MODE_CONT));
  assign stop_req = wr_cmd && i_wdata[AIC_CMD_STOP_BIT];

  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    nxt_frst = 1'b0;
    nxt_cont = cont_ff;
    nxt_swap = swap_ff;
    nxt_load = 1'b0;
    nxt_norm = norm_ff;
    nxt_swap_val = swap_val_ff;
    seq_done = 1'b0;
    seq_code = i_conv_data;
    case (state_ff)
      AIC_ST_IDLE: begin
        if (start_req && az_ff) begin
          // Each cancelled result starts from a cleared filter, normal polarity.
          nxt_frst = 1'b1;
          nxt_start = 1'b1;
          nxt_swap = 1'b0;
          nxt_cont = 1'b0;
          nxt_state = AIC_ST_NORM; // see RULE_08
        end else if (start_req) begin
          nxt_start = 1'b1;
          nxt_swap = 1'b0; // see RULE_07
          nxt_cont = (mode_ff == AIC_MODE_CONT);
          nxt_state = AIC_ST_CONV;
        end
      end
      AIC_ST_CONV: begin
        if (stop_req) begin
          nxt_cont = 1'b0;
          nxt_state = AIC_ST_IDLE;
        end else if (i_conv_done) begin
          seq_done = 1'b1;
          if (!cont_ff) begin
            nxt_state = AIC_ST_IDLE;
          end
        end
      end
      AIC_ST_NORM: begin
        if (stop_req) begin
          nxt_swap = 1'b0;
          nxt_state = AIC_ST_IDLE;
        end else if (i_conv_done) begin
          // Second half of the pair: this is what doubles the time per result.
          nxt_norm = i_conv_data;
          nxt_frst = 1'b1;
          nxt_start = 1'b1;
          nxt_swap = 1'b1; // see RULE_08 see RULE_10
          nxt_state = AIC_ST_SWAP;
        end
      end
      AIC_ST_SWAP: begin
        if (stop_req) begin
          nxt_swap = 1'b0;
          nxt_state = AIC_ST_IDLE;
        end else if (i_conv_done) begin
          nxt_swap_val = i_conv_data;
          nxt_load = 1'b1;
          nxt_swap = 1'b0;
          if (mode_ff == AIC_MODE_CONT) begin
            // Next pair starts in the same cycle, overlapping the combine step.
            nxt_frst = 1'b1; // see RULE_11
            nxt_start = 1'b1; // see RULE_11
            nxt_state = AIC_ST_NORM;
          end else begin
            nxt_state = AIC_ST_JOIN;
          end
        end
      end
      AIC_ST_JOIN: begin
        if (join_valid) begin
          nxt_state = AIC_ST_IDLE;
        end
      end
      default: begin
        nxt_swap = 1'b0;
        nxt_cont = 1'b0;
        nxt_state = AIC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= AIC_ST_IDLE;
      start_ff <= 1'b0;
      frst_ff <= 1'b0;
      cont_ff <= 1'b0;
      swap_ff <= 1'b0;
      load_ff <= 1'b0;
      norm_ff <= '0;
      swap_val_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= nxt_start;
      frst_ff <= nxt_frst;
      cont_ff <= nxt_cont;
      swap_ff <= nxt_swap;
      load_ff <= nxt_load;
      norm_ff <= nxt_norm;
      swap_val_ff <= nxt_swap_val;
    end
  end

  aic_join u_join (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_load (load_ff),
    .i_norm (norm_ff),
    .i_swap (swap_val_ff),
    .o_valid (join_valid),
    .o_code (join_code)
  );

  // ==========================================================================
  // Result and ready flag
  // A new result in the cycle of a data read keeps the flag set.
  always_comb begin
    nxt_result = result_ff;
    nxt_ready = ready_ff;
    if (i_rd && (i_addr == AIC_OFF_DATA)) begin
      nxt_ready = 1'b0;
    end
    if (join_valid) begin
      nxt_result = join_code; // see RULE_09
      nxt_ready = 1'b1; // see RULE_13
    end else if (seq_done) begin
      nxt_result = seq_code;
      nxt_ready = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      result_ff <= nxt_result;
      ready_ff <= nxt_ready;
    end
  end

  // ==========================================================================
  // Register read port
  always_comb begin
    nxt_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        AIC_OFF_BIAS: nxt_rdata[AIC_CS_LSB +: 2] = cs_sel_ff;
        AIC_OFF_PAIR: nxt_rdata[7:0] = pair_ff;
        AIC_OFF_CONV: begin
          nxt_rdata[AIC_MODE_LSB +: 2] = mode_ff;
          nxt_rdata[AIC_AZ_BIT] = az_ff;
        end
        AIC_OFF_STAT: begin
          nxt_rdata[AIC_STAT_READY_BIT] = ready_ff;
          nxt_rdata[AIC_STAT_BUSY_BIT] = (state_ff != AIC_ST_IDLE);
          nxt_rdata[AIC_STAT_SWAP_BIT] = swap_ff;
          nxt_rdata[AIC_STAT_DIODE_BIT] = diode_ff;
        end
        AIC_OFF_DATA: nxt_rdata = {{(AIC_DW-AIC_RES_W){result_ff[AIC_RES_W-1]}}, result_ff};
        AIC_OFF_NORM: nxt_rdata = {{(AIC_DW-AIC_RES_W){norm_ff[AIC_RES_W-1]}}, norm_ff};
        AIC_OFF_SWAP: nxt_rdata = {{(AIC_DW-AIC_RES_W){swap_val_ff[AIC_RES_W-1]}}, swap_val_ff};
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_rdata = rdata_ff;
  assign o_conv_start = start_ff;
  assign o_filter_rst = frst_ff;
  assign o_cont_run = cont_ff;
  assign o_swap = swap_ff;
  assign o_pos_sel = pos_ff;
  assign o_neg_sel = neg_ff;
  assign o_src_amp = src_ff;
  assign o_snk_amp = snk_ff;
  assign o_diode_bias = diode_ff;
  assign o_ready = ready_ff;

  // Busy is registered from the next state, so it tracks the state register: any state but idle.
  logic busy_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != AIC_ST_IDLE);
    end
  end
  assign o_busy = busy_ff;

endmodule

`default_nettype wire

// File: aic_ctl_checker.sv
// Purpose: Port level assertions for the controller.
// Assumes: Mode and cancel settings change only while idle.
// Notes: Mirrors the setting register.
`timescale 1ns/1ps
`default_nettype none

module aic_ctl_checker
  import aic_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic [AIC_AW-1:0] i_addr, // Offset.
  input wire logic [AIC_DW-1:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  input wire logic [AIC_DW-1:0] o_rdata, // Read data.
  input wire logic i_scan_temp, // Scan diode step.
  input wire logic i_conv_done, // Conversion done.
  input wire logic o_conv_start, // Start pulse.
  input wire logic o_filter_rst, // Filter clear.
  input wire logic o_swap, // Swapped inputs.
  input wire logic [2:0] o_src_amp, // Source current.
  input wire logic [2:0] o_snk_amp, // Sink current.
  input wire logic o_diode_bias, // Diode bias.
  input wire logic o_busy, // Busy.
  input wire logic o_ready // Ready.
);
  // ==========================================================================
  // Setting mirror
  logic [2:0] cfg_ff, nxt_cfg;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (i_wr && i_addr == AIC_OFF_CONV) nxt_cfg = i_wdata[2:0];
  end

  always_ff @(posedge i_clk) begin
    cfg_ff <= i_rst ? 3'h0 : nxt_cfg;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // ==========================================================================
  // Assertions
  a_amp_mirror: assert property (o_src_amp == o_snk_amp)
    else $error("sink differs from source");
  a_bias_decode: assert property (i_wr && i_addr == AIC_OFF_BIAS |-> ##2 o_diode_bias ||
    o_src_amp == 3'((4'h1 << $past(i_wdata[1:0], 2)) >> 1))
    else $error("bad burnout amplitude");
  a_diode_mask: assert property (o_diode_bias |-> o_src_amp == 3'h0)
    else $error("burnout on with diode bias");
  a_scan_diode: assert property (i_scan_temp ##1 i_scan_temp |=> o_diode_bias)
    else $error("scan missed diode bias");
  a_start_pulse: assert property (i_wr && i_addr == AIC_OFF_CMD && i_wdata[0] && !o_busy &&
    cfg_ff[1] |=> o_conv_start && o_busy && !o_swap && (!cfg_ff[2] || o_filter_rst))
    else $error("start not launched");
  a_swap_half: assert property (cfg_ff[2] && o_busy && !o_swap && i_conv_done |=>
    o_conv_start && o_filter_rst && o_swap)
    else $error("no swapped half");
  a_join_ready: assert property (cfg_ff[2] && o_swap && i_conv_done |=> !o_swap ##2 o_ready)
    else $error("late combined result");
  a_cont_nogap: assert property (cfg_ff == 3'h7 && o_swap && i_conv_done |=>
    o_conv_start && o_filter_rst)
    else $error("pair did not restart");
  a_plain_swap: assert property (!cfg_ff[2] |-> !o_swap)
    else $error("swap with cancel off");
  a_plain_done: assert property (cfg_ff == 3'h2 && o_busy &&
    i_conv_done |=> o_ready && !o_busy)
    else $error("no single result");
  a_rdata_zero: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data without read");
endmodule

bind aic_ctl aic_ctl_checker aic_ctl_checker_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_scan_temp(i_scan_temp), .i_conv_done(i_conv_done),
  .o_conv_start(o_conv_start), .o_filter_rst(o_filter_rst), .o_swap(o_swap),
  .o_src_amp(o_src_amp), .o_snk_amp(o_snk_amp), .o_diode_bias(o_diode_bias),
  .o_busy(o_busy), .o_ready(o_ready)
);

`default_nettype wire

// File: aic_join.sv
// Purpose: Forms the offset cancelled code from a normal and a swapped conversion.
// Assumes: Both inputs are two's complement codes held stable during i_load.
// Notes: One cycle of latency from i_load to o_valid.
`timescale 1ns/1ps
`default_nettype none

module aic_join
  import aic_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic i_load, // Pulse: both halves present.
  input wire logic [AIC_RES_W-1:0] i_norm, // Normal polarity code.
  input wire logic [AIC_RES_W-1:0] i_swap, // Swapped polarity code.
  output logic o_valid, // Pulse: o_code updated.
  output logic [AIC_RES_W-1:0] o_code // Combined code.
);

  logic valid_ff;
  logic nxt_valid;
  logic [AIC_RES_W-1:0] code_ff;
  logic [AIC_RES_W-1:0] nxt_code;

  always_comb begin
    nxt_valid = i_load;
    nxt_code = code_ff;
    if (i_load) begin
      // The extra sign bit keeps full-scale differences from wrapping.
      nxt_code = aic_half_diff(i_norm, i_swap); // see RULE_09
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      valid_ff <= 1'b0;
      code_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      code_ff <= nxt_code;
    end
  end

  assign o_valid = valid_ff;
  assign o_code = code_ff;

endmodule

`default_nettype wire

// File: aic_pkg.sv
// Purpose: Shared constants, types and helpers for the input bias and offset cancel block.
// Assumes: 32-bit register port with one word per offset, 24-bit signed conversion codes.
// Notes: Offsets are word indices on the plain register port.

package aic_pkg;

  // ==========================================================================
  // Widths
  localparam int AIC_AW = 4;
  localparam int AIC_DW = 32;
  localparam int AIC_RES_W = 24;

  // ==========================================================================
  // Register offsets
  localparam logic [AIC_AW-1:0] AIC_OFF_BIAS = 4'h0;
  localparam logic [AIC_AW-1:0] AIC_OFF_PAIR = 4'h1;
  localparam logic [AIC_AW-1:0] AIC_OFF_CONV = 4'h2;
  localparam logic [AIC_AW-1:0] AIC_OFF_CMD = 4'h3;
  localparam logic [AIC_AW-1:0] AIC_OFF_STAT = 4'h4;
  localparam logic [AIC_AW-1:0] AIC_OFF_DATA = 4'h5;
  localparam logic [AIC_AW-1:0] AIC_OFF_NORM = 4'h6;
  localparam logic [AIC_AW-1:0] AIC_OFF_SWAP = 4'h7;

  // ==========================================================================
  // Field positions
  localparam int AIC_CS_LSB = 0;
  localparam int AIC_MODE_LSB = 0;
  localparam int AIC_AZ_BIT = 2;
  localparam int AIC_CMD_START_BIT = 0;
  localparam int AIC_CMD_STOP_BIT = 1;
  localparam int AIC_STAT_READY_BIT = 0;
  localparam int AIC_STAT_BUSY_BIT = 1;
  localparam int AIC_STAT_SWAP_BIT = 2;
  localparam int AIC_STAT_DIODE_BIT = 3;

  // ==========================================================================
  // Reset values and codes
  localparam logic [1:0] AIC_CS_RST = 2'h0;
  localparam logic [7:0] AIC_PAIR_RST = 8'h01;
  localparam logic [1:0] AIC_MODE_RST = 2'h0;
  localparam logic AIC_AZ_RST = 1'b0;
  localparam logic [1:0] AIC_CS_OFF = 2'h0;
  localparam logic [1:0] AIC_CS_LOW = 2'h1;
  localparam logic [1:0] AIC_CS_MID = 2'h2;
  localparam logic [1:0] AIC_CS_HIGH = 2'h3;
  localparam logic [1:0] AIC_MODE_ONESHOT = 2'h2;
  localparam logic [1:0] AIC_MODE_CONT = 2'h3;
  localparam logic [3:0] AIC_SEL_TEMP_P = 4'hd;
  localparam logic [3:0] AIC_SEL_TEMP_M = 4'he;
  localparam logic [2:0] AIC_AMP_NONE = 3'h0;
  localparam logic [2:0] AIC_AMP_LOW = 3'h1;
  localparam logic [2:0] AIC_AMP_MID = 3'h2;
  localparam logic [2:0] AIC_AMP_HIGH = 3'h4;

  // ==========================================================================
  // Types
  typedef enum logic [4:0] {
    AIC_ST_IDLE = 5'h01,
    AIC_ST_CONV = 5'h02,
    AIC_ST_NORM = 5'h04,
    AIC_ST_SWAP = 5'h08,
    AIC_ST_JOIN = 5'h10
  } aic_seq_e;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] aic_amp_decode(input logic [1:0] cs);
    logic [2:0] amp;
    case (cs)
      AIC_CS_LOW: amp = AIC_AMP_LOW;
      AIC_CS_MID: amp = AIC_AMP_MID;
      AIC_CS_HIGH: amp = AIC_AMP_HIGH;
      default: amp = AIC_AMP_NONE;
    endcase
    return amp;
  endfunction

  function automatic logic [AIC_RES_W-1:0] aic_half_diff(input logic [AIC_RES_W-1:0] a,
                                                         input logic [AIC_RES_W-1:0] b);
    logic [AIC_RES_W:0] diff;
    diff = {a[AIC_RES_W-1], a} - {b[AIC_RES_W-1], b};
    return diff[AIC_RES_W:1];
  endfunction

endpackage

// File: tb_top.sv
// Purpose: Self-checking bench for the controller.
// Assumes: The bench is both register master and decimation filter.
// Notes: Outputs are sampled 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  import aic_pkg::*;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [AIC_AW-1:0] i_addr = '0;
  logic [AIC_DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_scan_temp = 1'b0, i_conv_done = 1'b0;
  logic [AIC_RES_W-1:0] i_conv_data = '0;
  logic [AIC_DW-1:0] o_rdata;
  logic o_conv_start, o_filter_rst, o_cont_run, o_swap, o_diode_bias, o_busy, o_ready;
  logic [3:0] o_pos_sel, o_neg_sel;
  logic [2:0] o_src_amp, o_snk_amp;
  int mismatches = 0, comparisons = 0;

  always #50 i_clk = ~i_clk;

  aic_ctl aic_ctl_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_scan_temp(i_scan_temp), .i_conv_done(i_conv_done),
    .i_conv_data(i_conv_data), .o_conv_start(o_conv_start), .o_filter_rst(o_filter_rst),
    .o_cont_run(o_cont_run), .o_swap(o_swap), .o_pos_sel(o_pos_sel), .o_neg_sel(o_neg_sel),
    .o_src_amp(o_src_amp), .o_snk_amp(o_snk_amp), .o_diode_bias(o_diode_bias),
    .o_busy(o_busy), .o_ready(o_ready)
  );

  // ==========================================================================
  // Tasks
  task automatic settle;
    @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [AIC_AW-1:0] a, input logic [AIC_DW-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AIC_AW-1:0] a, input logic [AIC_DW-1:0] e, input string nm);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, e, o_rdata)
  endtask

  // Stale codes are inverted so they never look valid.
  task automatic done(input logic [AIC_RES_W-1:0] d);
    @(posedge i_clk);
    i_conv_done <= 1'b1;
    i_conv_data <= d;
    @(posedge i_clk);
    i_conv_done <= 1'b0;
    i_conv_data <= ~d;
  endtask

  task automatic wait_start(input logic sw);
    int n = 0;
    #1;
    while (o_conv_start !== 1'b1 && n < 20) begin
      settle;
      n++;
    end
    `CHK("start", 1'b1, o_conv_start)
    `CHK("swap", sw, o_swap)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    `CHK("pos reset", 4'h0, o_pos_sel)
    `CHK("neg reset", 4'h1, o_neg_sel)
    rd(AIC_OFF_CONV, 32'h0, "conv reset");
    rd(4'hf, 32'h0, "unmapped");
  endtask

  task automatic t_bias;
    logic [2:0] amp [4] = '{AIC_AMP_NONE, AIC_AMP_LOW, AIC_AMP_MID, AIC_AMP_HIGH};
    for (int i = 0; i < 4; i++) begin
      wr(AIC_OFF_BIAS, 32'(i));
      settle;
      `CHK("src amp", amp[i], o_src_amp)
      `CHK("snk amp", amp[i], o_snk_amp)
      rd(AIC_OFF_BIAS, 32'(i), "cs");
    end
  endtask

  task automatic t_diode;
    wr(AIC_OFF_PAIR, 32'hde);
    settle;
    `CHK("pos diode", 4'hd, o_pos_sel)
    `CHK("neg diode", 4'he, o_neg_sel)
    `CHK("diode bias", 1'b1, o_diode_bias)
    `CHK("src masked", AIC_AMP_NONE, o_src_amp)
    rd(AIC_OFF_BIAS, 32'h3, "cs kept");
    wr(AIC_OFF_PAIR, 32'h23);
    settle;
    `CHK("src back", AIC_AMP_HIGH, o_src_amp)
    @(posedge i_clk);
    i_scan_temp <= 1'b1;
    repeat (2) settle;
    `CHK("scan diode", 1'b1, o_diode_bias)
    `CHK("scan masked", AIC_AMP_NONE, o_snk_amp)
    @(posedge i_clk);
    i_scan_temp <= 1'b0;
  endtask

  task automatic t_plain;
    wr(AIC_OFF_CONV, 32'h2);
    wr(AIC_OFF_CMD, 32'h1);
    wait_start(1'b0);
    wr(AIC_OFF_BIAS, 32'h1);
    settle;
    `CHK("busy bias", AIC_AMP_LOW, o_src_amp)
    done(24'h800005);
    #1;
    `CHK("plain ready", 1'b1, o_ready)
    rd(AIC_OFF_DATA, 32'hff800005, "plain data");
    `CHK("ready clr", 1'b0, o_ready)
  endtask

  task automatic t_cancel;
    int va [3] = '{100, -7, 8388607};
    int vb [3] = '{-51, 2, -8388608};
    wr(AIC_OFF_CONV, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wr(AIC_OFF_CMD, 32'h1);
      wait_start(1'b0);
      `CHK("frst", 1'b1, o_filter_rst)
      done(24'(va[i]));
      wait_start(1'b1);
      `CHK("pos swapped", 4'h3, o_pos_sel)
      `CHK("early ready", 1'b0, o_ready)
      done(24'(vb[i]));
      #1;
      `CHK("join ready", 1'b0, o_ready)
      repeat (2) settle;
      `CHK("pair ready", 1'b1, o_ready)
      `CHK("pair idle", 1'b0, o_busy)
      rd(AIC_OFF_DATA, 32'((va[i] - vb[i]) >>> 1), "pair data");
      rd(AIC_OFF_SWAP, 32'(vb[i]), "swap code");
    end
  endtask

  task automatic t_cont;
    wr(AIC_OFF_CONV, 32'h7);
    wr(AIC_OFF_CMD, 32'h1);
    wait_start(1'b0);
    for (int k = 0; k < 2; k++) begin
      done(24'(k + 3));
      wait_start(1'b1);
      done(24'h0);
      #1;
      `CHK("cont restart", 1'b1, o_conv_start)
      `CHK("cont frst", 1'b1, o_filter_rst)
      `CHK("cont unswap", 1'b0, o_swap)
    end
    settle;
    rd(AIC_OFF_DATA, 32'h2, "cont data");
    wr(AIC_OFF_CMD, 32'h2);
    #1;
    `CHK("stop idle", 1'b0, o_busy)
    wr(AIC_OFF_CONV, 32'h3);
    wr(AIC_OFF_CMD, 32'h1);
    #1;
    `CHK("free run", 1'b1, o_cont_run)
    done(24'h5);
    #1;
    `CHK("free ready", 1'b1, o_ready)
    wr(AIC_OFF_CMD, 32'h2);
    #1;
    `CHK("free stop", 1'b0, o_cont_run)
  endtask

  // ==========================================================================
  // Run and verdict
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    t_reset;
    t_bias;
    t_diode;
    t_plain;
    t_cancel;
    t_cont;
    results;
  end

  // A run needs a little over a hundred cycles; 5000 means a hang.
  initial begin
    #500000;
    mismatches++;
    results;
  end
endmodule

`default_nettype wire
